// >>> logic/logic_op_decode_timing.sv
// Logical and rotate-through-carry execution with instruction timing
`timescale 1ns/1ns
module logic_op_decode_timing
	import logic_op_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic start,
	input wire issue_t issue,
	input wire opnd_t opnd,
	output logic busy_q,
	output logic done_q,
	output logic unsup_q,
	output result_t res_q,
	output logic [1:0] len_q,
	output logic [1:0] cyc_q
);

	decode_t dec;
	logic take;
	logic finish;
	logic [7:0] opx;
	logic [7:0] opy;
	logic [7:0] value;
	logic carry_n;
	result_t calc;
	state_t state_q;
	state_t state_d;
	logic [1:0] remain_q;
	result_t pend_q;
	logic pend_unsup_q;
	logic [1:0] pend_len_q;
	logic [1:0] pend_cyc_q;

	logic_op_decoder u_dec (
		.opcode(issue.opcode),
		.dec(dec)
	);

	// Requests during a multi-clock instruction are ignored, not queued
	assign take = start && (state_q == ST_IDLE);

	// Operands are sampled at issue so the core may move on
	always_comb begin
		opx = dec.dst_mem ? opnd.mem_val : opnd.acc;
		case (dec.src)
			SRC_REG: opy = opnd.reg_val;
			SRC_MEM: opy = opnd.mem_val;
			SRC_IMM1: opy = issue.imm1;
			SRC_ACC: opy = opnd.acc;
			SRC_IMM2: opy = issue.imm2;
			default: opy = '0;
		endcase
	end

	always_comb begin
		value = opnd.acc;
		carry_n = opnd.carry;
		case (dec.func)
			FN_AND: value = opx & opy;
			FN_OR: value = opx | opy;
			FN_XOR: value = opx ^ opy;
			FN_RLC: begin
				value = {opnd.acc[ACC_MSB-1:0], opnd.carry};
				carry_n = opnd.acc[ACC_MSB];
			end
			default: value = opnd.acc;
		endcase
	end

	always_comb begin
		calc.mem_we = dec.legal && dec.dst_mem && (dec.func != FN_RLC);
		calc.acc_we = dec.legal && !dec.dst_mem;
		calc.carry_we = (dec.func == FN_RLC);
		calc.mem_addr = dec.dst_mem ? issue.imm1 : '0;
		calc.data = value;
		calc.carry = carry_n;
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (take && dec.cyc != CNT_1) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (remain_q == CNT_1) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	assign finish = (take && dec.cyc == CNT_1) || (state_q == ST_RUN && remain_q == CNT_1);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_IDLE;
			busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			busy_q <= (state_d == ST_RUN);
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			remain_q <= CNT_0;
		end else if (take) begin
			remain_q <= dec.cyc - CNT_1;
		end else if (state_q == ST_RUN) begin
			remain_q <= remain_q - CNT_1;
		end
	end

	// Held result keeps write strobes away from the core until completion
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pend_q <= '0;
			pend_unsup_q <= 1'b0;
			pend_len_q <= CNT_0;
			pend_cyc_q <= CNT_0;
		end else if (take) begin
			pend_q <= calc;
			pend_unsup_q <= !dec.legal;
			pend_len_q <= dec.len;
			pend_cyc_q <= dec.cyc;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			done_q <= 1'b0;
			unsup_q <= 1'b0;
			res_q <= '0;
			len_q <= CNT_0;
			cyc_q <= CNT_0;
		end else begin
			done_q <= finish;
			if (finish) begin
				res_q <= take ? calc : pend_q;
				unsup_q <= take ? !dec.legal : pend_unsup_q;
				len_q <= take ? dec.len : pend_len_q;
				cyc_q <= take ? dec.cyc : pend_cyc_q;
			end else begin
				res_q.acc_we <= 1'b0;
				res_q.mem_we <= 1'b0;
				res_q.carry_we <= 1'b0;
				unsup_q <= 1'b0;
			end
		end
	end

	// Checks below watch the outputs against the issued opcode
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	logic grp_ok;
	logic [3:0] form;
	logic [1:0] meas_q;
	assign grp_ok = issue.opcode[7:4] inside {GRP_AND, GRP_OR, GRP_XOR};
	assign form = issue.opcode[3:0];

	// Clocks since issue, for comparison at completion
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			meas_q <= CNT_0;
		end else if (take) begin
			meas_q <= CNT_1;
		end else if (busy_q) begin
			meas_q <= meas_q + CNT_1;
		end
	end

	sequence s_hold1;
		busy_q && !done_q;
	endsequence

	sequence s_hold2;
		s_hold1 ##1 s_hold1;
	endsequence

	a_reg_one_clock: assert property (
		take && grp_ok && form >= FORM_REG0 |-> ##1 done_q && res_q.acc_we && len_q == CNT_1 && cyc_q == CNT_1)
		else $error("register form not one byte one clock");

	a_acc_two_clock: assert property (
		take && grp_ok && (form == FORM_A_DIR || form == FORM_A_IMM)
		|-> ##1 s_hold1 ##1 done_q && res_q.acc_we && !res_q.mem_we && len_q == CNT_2)
		else $error("direct or immediate into A not two clocks");

	a_indirect_timing: assert property (
		take && grp_ok && (form == FORM_IND0 || form == FORM_IND1)
		|-> ##1 s_hold1 ##1 done_q && res_q.acc_we && len_q == CNT_1 && cyc_q == CNT_2)
		else $error("indirect form not one byte two clocks");

	a_dir_acc_wb: assert property (
		take && grp_ok && form == FORM_DIR_A |-> ##1 s_hold1 ##1 done_q && res_q.mem_we && !res_q.acc_we
		&& res_q.mem_addr == $past(issue.imm1, 2) && len_q == CNT_2)
		else $error("write back of A to direct byte wrong");

	a_dir_imm_wb: assert property (
		take && grp_ok && form == FORM_DIR_IMM |-> ##1 s_hold2 ##1 done_q && res_q.mem_we
		&& res_q.mem_addr == $past(issue.imm1, 3) && len_q == CNT_3 && cyc_q == CNT_3)
		else $error("immediate to direct byte not three clocks");

	a_or_value: assert property (
		take && issue.opcode[7:4] == GRP_OR && form >= FORM_REG0
		|-> ##1 res_q.data == ($past(opnd.acc) | $past(opnd.reg_val)))
		else $error("OR result wrong");

	a_xor_value: assert property (
		take && issue.opcode[7:4] == GRP_XOR && form == FORM_A_IMM
		|-> ##2 done_q && res_q.data == ($past(opnd.acc, 2) ^ $past(issue.imm1, 2)))
		else $error("XOR result wrong");

	a_rlc_ring: assert property (
		take && issue.opcode == OPC_RLC |-> ##1 done_q && res_q.acc_we && res_q.carry_we
		&& res_q.data == {$past(opnd.acc[ACC_MSB-1:0]), $past(opnd.carry)} && res_q.carry == $past(opnd.acc[ACC_MSB]))
		else $error("rotate through carry wrong");

	a_flags_kept: assert property (
		take && grp_ok |-> ##1 !res_q.carry_we [*3])
		else $error("logical op wrote carry");

	a_clock_count: assert property (
		done_q && !unsup_q |-> meas_q == cyc_q && !busy_q)
		else $error("measured clocks differ from reported count");

endmodule : logic_op_decode_timing

// >>> inc/logic_op_pkg.sv
// Shared types and constants for the logic-op decode and timing block
package logic_op_pkg;

	// Opcode groups (high nibble) and operand forms (low nibble)
	localparam logic [7:0] OPC_RLC = 8'h33;
	localparam logic [3:0] GRP_OR = 4'h4;
	localparam logic [3:0] GRP_AND = 4'h5;
	localparam logic [3:0] GRP_XOR = 4'h6;
	localparam logic [3:0] FORM_DIR_A = 4'h2;
	localparam logic [3:0] FORM_DIR_IMM = 4'h3;
	localparam logic [3:0] FORM_A_IMM = 4'h4;
	localparam logic [3:0] FORM_A_DIR = 4'h5;
	localparam logic [3:0] FORM_IND0 = 4'h6;
	localparam logic [3:0] FORM_IND1 = 4'h7;
	localparam logic [3:0] FORM_REG0 = 4'h8;

	// Byte lengths and clock counts share one encoding
	localparam logic [1:0] CNT_0 = 2'h0;
	localparam logic [1:0] CNT_1 = 2'h1;
	localparam logic [1:0] CNT_2 = 2'h2;
	localparam logic [1:0] CNT_3 = 2'h3;

	// Accumulator sign bit, carried out by the rotate
	localparam int ACC_MSB = 7;

	typedef enum logic [2:0] {FN_NONE, FN_AND, FN_OR, FN_XOR, FN_RLC} func_t;
	typedef enum logic [2:0] {SRC_NONE, SRC_REG, SRC_MEM, SRC_IMM1, SRC_ACC, SRC_IMM2} src_t;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RUN = 2'b01} state_t;

	typedef struct packed {
		logic legal;
		func_t func;
		src_t src;
		logic dst_mem;
		logic [1:0] len;
		logic [1:0] cyc;
	} decode_t;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] imm1;
		logic [7:0] imm2;
	} issue_t;

	typedef struct packed {
		logic [7:0] acc;
		logic carry;
		logic [7:0] reg_val;
		logic [7:0] mem_val;
	} opnd_t;

	typedef struct packed {
		logic acc_we;
		logic mem_we;
		logic carry_we;
		logic [7:0] mem_addr;
		logic [7:0] data;
		logic carry;
	} result_t;

endpackage : logic_op_pkg

// >>> logic/logic_op_decoder.sv
// Opcode decoder: function, operand source, length and clock count
`timescale 1ns/1ns
module logic_op_decoder
	import logic_op_pkg::*;
(
	input wire logic [7:0] opcode,
	output decode_t dec
);

	logic [3:0] grp;
	logic [3:0] form;
	assign grp = opcode[7:4];
	assign form = opcode[3:0];

	always_comb begin
		dec = '{legal: 1'b0, func: FN_NONE, src: SRC_NONE, dst_mem: 1'b0, len: CNT_1, cyc: CNT_1};
		if (opcode == OPC_RLC) begin
			dec.legal = 1'b1;
			dec.func = FN_RLC;
		end else if ((grp == GRP_AND || grp == GRP_OR || grp == GRP_XOR) && form >= FORM_DIR_A) begin
			dec.legal = 1'b1;
			case (grp)
				GRP_AND: dec.func = FN_AND;
				GRP_OR: dec.func = FN_OR;
				default: dec.func = FN_XOR;
			endcase
			case (form)
				FORM_DIR_A: begin
					dec.src = SRC_ACC;
					dec.dst_mem = 1'b1;
					dec.len = CNT_2;
					dec.cyc = CNT_2;
				end
				FORM_DIR_IMM: begin
					dec.src = SRC_IMM2;
					dec.dst_mem = 1'b1;
					dec.len = CNT_3;
					dec.cyc = CNT_3;
				end
				FORM_A_IMM: begin
					dec.src = SRC_IMM1;
					dec.len = CNT_2;
					dec.cyc = CNT_2;
				end
				FORM_A_DIR: begin
					dec.src = SRC_MEM;
					dec.len = CNT_2;
					dec.cyc = CNT_2;
				end
				FORM_IND0, FORM_IND1: begin
					dec.src = SRC_MEM;
					dec.cyc = CNT_2;
				end
				default: begin
					dec.src = SRC_REG;
				end
			endcase
		end
	end

endmodule : logic_op_decoder

// >>> sim/tb_top.sv
// Self-checking bench for the logic-op decode and timing block
`timescale 1ns/1ns
module tb_top;
	import logic_op_pkg::*;
	logic core_clk;
	logic rst_b;
	logic start;
	issue_t issue;
	opnd_t opnd;
	logic busy_q;
	logic done_q;
	logic unsup_q;
	result_t res_q;
	logic [1:0] len_q;
	logic [1:0] cyc_q;
	int miscompares;
	int check_count;
	int cycles;
	logic [3:0] grp [3] = '{GRP_OR, GRP_AND, GRP_XOR};

	logic_op_decode_timing u_dut (.core_clk(core_clk), .rst_b(rst_b), .start(start), .issue(issue), .opnd(opnd),
		.busy_q(busy_q), .done_q(done_q), .unsup_q(unsup_q), .res_q(res_q), .len_q(len_q), .cyc_q(cyc_q));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// Run is near 130 cycles; a hang ends it
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			miscompares++;
			stop_test();
		end
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic stop_test();
		$display("Checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test

	// Fixed operands: reg 3a, mem 96, imm1 21, imm2 5c
	task automatic run_op(input logic [7:0] op, input logic [7:0] a, input logic cy);
		result_t r;
		logic [7:0] x;
		logic [7:0] y;
		logic [3:0] lo;
		logic [1:0] l;
		logic [1:0] c;
		logic u;
		int n;
		lo = op[3:0];
		r = '0;
		u = 1'b1;
		l = 2'h1;
		c = 2'h1;
		x = (lo < FORM_A_IMM) ? 8'h96 : a;
		y = (lo >= FORM_REG0) ? 8'h3a : (lo == FORM_A_IMM) ? 8'h21 : (lo == FORM_DIR_IMM) ? 8'h5c :
			(lo == FORM_DIR_A) ? a : 8'h96;
		if (op == OPC_RLC) begin
			r.acc_we = 1'b1;
			r.carry_we = 1'b1;
			r.data = {a[6:0], cy};
			r.carry = a[ACC_MSB];
			u = 1'b0;
		end else if ((op[7:4] == GRP_OR || op[7:4] == GRP_AND || op[7:4] == GRP_XOR) && lo >= FORM_DIR_A) begin
			u = 1'b0;
			r.data = (op[7:4] == GRP_OR) ? (x | y) : (op[7:4] == GRP_AND) ? (x & y) : (x ^ y);
			r.mem_we = lo < FORM_A_IMM;
			r.acc_we = !r.mem_we;
			r.mem_addr = r.mem_we ? 8'h21 : 8'h00;
			l = (lo == FORM_DIR_IMM) ? 2'h3 : (lo >= FORM_IND0) ? 2'h1 : 2'h2;
			c = (lo == FORM_DIR_IMM) ? 2'h3 : (lo >= FORM_REG0) ? 2'h1 : 2'h2;
		end
		@(posedge core_clk);
		#2;
		start = 1'b1;
		issue = '{op, 8'h21, 8'h5c};
		opnd = '{a, cy, 8'h3a, 8'h96};
		n = 0;
		do begin
			@(posedge core_clk);
			#2;
			n++;
			// Stray request while busy must be ignored
			start = !done_q;
			issue.opcode = 8'h00;
			opnd.acc = ~a;
			if (!done_q && n < 8) chk("busy", busy_q, 1'b1);
		end while (!done_q && n < 8);
		start = 1'b0;
		chk("cycles", n, c);
		chk("unsup", unsup_q, u);
		chk("busy_done", busy_q, 1'b0);
		chk("we", {res_q.acc_we, res_q.mem_we, res_q.carry_we}, {r.acc_we, r.mem_we, r.carry_we});
		chk("len", len_q, l);
		chk("cyc", cyc_q, c);
		if (!u) begin
			chk("data", res_q.data, r.data);
			chk("addr", res_q.mem_addr, r.mem_addr);
		end
		if (r.carry_we) chk("carry", res_q.carry, r.carry);
		@(posedge core_clk);
		#2;
		chk("pulse", {done_q, res_q.acc_we, res_q.mem_we, res_q.carry_we}, 4'h0);
	endtask : run_op

	task automatic forms(input logic [3:0] f0, input logic [3:0] f1);
		for (int i = 0; i < 3; i++) begin
			run_op({grp[i], f0}, 8'hc5, 1'b1);
			run_op({grp[i], f1}, 8'h0f, 1'b0);
		end
	endtask : forms

	task automatic t_reset();
		chk("reset", {busy_q, done_q, unsup_q, res_q, len_q, cyc_q}, 32'h0);
	endtask : t_reset

	// One-clock ops may be issued in the done cycle of the previous one
	task automatic t_b2b();
		@(posedge core_clk);
		#2;
		start = 1'b1;
		issue = '{OPC_RLC, 8'h21, 8'h5c};
		opnd = '{8'h81, 1'b0, 8'h3a, 8'h96};
		@(posedge core_clk);
		#2;
		opnd = '{8'h40, 1'b1, 8'h3a, 8'h96};
		chk("b2b_first", {done_q, res_q.data, res_q.carry}, {1'b1, 8'h02, 1'b1});
		@(posedge core_clk);
		#2;
		start = 1'b0;
		chk("b2b_second", {done_q, res_q.data, res_q.carry}, {1'b1, 8'h81, 1'b0});
		@(posedge core_clk);
		#2;
		chk("b2b_idle", done_q, 1'b0);
	endtask : t_b2b

	// Reset in the middle of a three-clock op, then a clean op
	task automatic t_mid_reset();
		@(posedge core_clk);
		#2;
		start = 1'b1;
		issue = '{{GRP_AND, FORM_DIR_IMM}, 8'h21, 8'h5c};
		@(posedge core_clk);
		#2;
		start = 1'b0;
		rst_b = 1'b0;
		#1;
		chk("mid_reset", {busy_q, done_q, unsup_q, res_q, len_q, cyc_q}, 32'h0);
		@(posedge core_clk);
		#2;
		rst_b = 1'b1;
		run_op({GRP_XOR, FORM_DIR_IMM}, 8'h3c, 1'b0);
	endtask : t_mid_reset

	task automatic t_reg();
		forms(FORM_REG0, 4'hf);
	endtask : t_reg

	task automatic t_acc_src();
		forms(FORM_A_IMM, FORM_A_DIR);
	endtask : t_acc_src

	task automatic t_ind();
		forms(FORM_IND0, FORM_IND1);
	endtask : t_ind

	task automatic t_dir_dst();
		forms(FORM_DIR_A, FORM_DIR_IMM);
	endtask : t_dir_dst

	task automatic t_rlc();
		run_op(OPC_RLC, 8'h80, 1'b0);
		run_op(OPC_RLC, 8'h4b, 1'b1);
	endtask : t_rlc

	// Forms 0 and 1 of the logic groups are not handled here
	task automatic t_unsup();
		run_op(8'h40, 8'hc5, 1'b1);
		run_op(8'h51, 8'hc5, 1'b1);
		run_op(8'h23, 8'hc5, 1'b1);
	endtask : t_unsup

	initial begin
		rst_b = 1'b0;
		start = 1'b0;
		issue = '0;
		opnd = '0;
		repeat (10) @(posedge core_clk);
		t_reset();
		#2;
		rst_b = 1'b1;
		t_reg();
		t_acc_src();
		t_ind();
		t_dir_dst();
		t_rlc();
		t_b2b();
		t_unsup();
		t_mid_reset();
		stop_test();
	end
endmodule : tb_top
